// *** core/pcbm_core.sv ***
`timescale 1ns/1ps
// Contract
// - NACK every command byte while saving all registers to nonvolatile memory.
// - NACK every command byte while reloading all registers, about 30 ms.
// - NACK every command byte while clearing the fault log area, 175 ms.
// - NACK every command byte while storing the fault log, 20 ms.
// - On a fault with logging enabled, store the log once for 10 ms, NACKing; only fault_event or a turn-on timeout starts it, not over-voltage.
// - NACK every command byte while loading the fault log, 2 ms.
// - NACK every command byte after a vendor config write, under 50 us.
// - Keep accepting after clear-faults; flags clear up to 500 us later.
// - Page register selects the channel for paged commands; resets to zero.
// - Operating_mode_ctrl byte sets on, off, margin high or low; resets to zero.
// - Output format byte reads as fixed 0x13.
// - Every commanded output value is clamped to the ceiling register.
// - Conversion may be enabled only above the input turn-on threshold.
// - Input below turn-off threshold drops every output enable at once.
// - Under-fault level decides channel-on and the turn-on timeout fault.
// - Protocol_feature_summary byte reads as fixed 0xE0.
// - Busy sets the status busy bit but never asserts the alert output.
module pcbm_core
  import pcbm_pkg::*;
#(
  parameter int MASS_CYC = T_MASS_MS * CYC_PER_MS,
  parameter int LOAD_ALL_CYC = T_LOAD_ALL_MS * CYC_PER_MS,
  parameter int LOG_CLEAR_CYC = T_LOG_CLEAR_MS * CYC_PER_MS,
  parameter int LOG_STORE_CYC = T_LOG_STORE_MS * CYC_PER_MS,
  parameter int LOG_AUTO_CYC = T_LOG_AUTO_MS * CYC_PER_MS,
  parameter int LOG_LOAD_CYC = T_LOG_LOAD_MS * CYC_PER_MS,
  parameter int CLEAR_CYC = T_CLEAR_US * CYC_PER_US,
  parameter int TON_MAX_CYC = T_TON_MAX_MS * CYC_PER_MS
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire pcbm_cmd_t cmd,
  output logic cmd_ack,
  output logic [15:0] rd_data_r,
  output logic rd_valid_r,
  input wire logic fault_event,
  input wire logic fault_log_en,
  input wire logic [15:0] input_sense_pin,
  input wire logic [NCH-1:0][15:0] vout_sense,
  output logic [NCH-1:0] output_enable_pin,
  output logic [NCH-1:0][15:0] vout_target_r,
  output logic [NCH-1:0] turn_on_timeout_fault,
  output logic busy_r,
  output logic [2:0] busy_kind_r,
  output logic alert_out_n
);
  pcbm_state_t state_r;
  logic [CNT_W-1:0] busy_cnt_r;
  logic [CNT_W-1:0] busy_len;
  logic [2:0] start_kind;
  logic cmd_take;
  logic wr_take;
  logic known;
  logic log_pend_r;
  logic log_done_r;
  logic busy_seen_r;
  logic clr_pend_r;
  logic [CNT_W-1:0] clr_cnt_r;
  logic [2:0] clr_page_r;
  logic clr_fire;
  logic [7:0] page_r;
  logic page_ok;
  logic [2:0] pg;
  logic [7:0] wlock_r;
  logic [15:0] vin_on_r;
  logic [15:0] vin_off_r;
  logic [15:0] ot_lvl_r;
  logic [7:0] oper_r [NCH];
  logic [7:0] on_off_r [NCH];
  logic [15:0] setpt_r [NCH];
  logic [15:0] ceil_r [NCH];
  logic [15:0] mhi_r [NCH];
  logic [15:0] mlo_r [NCH];
  logic [15:0] ov_lvl_r [NCH];
  logic [7:0] ov_act_r [NCH];
  logic [15:0] ovw_lvl_r [NCH];
  logic [15:0] uvw_lvl_r [NCH];
  logic [15:0] uv_lvl_r [NCH];
  logic [7:0] uv_act_r [NCH];
  logic input_ok_r;
  logic [NCH-1:0] en_r;
  logic [NCH-1:0] ov_flt_r;
  logic [NCH-1:0] ton_flt_r;
  logic [CNT_W-1:0] ton_cnt_r [NCH];
  logic [15:0] rd_nxt;
  logic any_fault;

  // Command code decode and take: refused while busy
  always_comb begin
    case (cmd.code)
      CODE_PAGE, CODE_OPERATING_MODE_CTRL, CODE_ON_OFF, CODE_CLEAR, CODE_WLOCK,
      CODE_SAVE_ALL, CODE_LOAD_ALL, CODE_CAPAB, CODE_VFMT, CODE_SETPT,
      CODE_CEIL, CODE_MHI, CODE_MLO, CODE_VIN_ON, CODE_VIN_OFF,
      CODE_OV_LVL, CODE_OV_ACT, CODE_OVW_LVL, CODE_UVW_LVL, CODE_UV_LVL,
      CODE_UV_ACT, CODE_OT_LVL, CODE_STAT_BYTE, CODE_STAT_WORD,
      CODE_STAT_VOUT, CODE_LOG_CLEAR, CODE_LOG_STORE, CODE_LOG_LOAD,
      CODE_VCFG: known = 1'b1;
      default: known = 1'b0;
    endcase
  end
  assign cmd_take = cmd.valid & known & (state_r == PCBM_IDLE);
  assign cmd_ack = cmd_take;
  assign wr_take = cmd_take & cmd.write;
  assign page_ok = (page_r < 8'(NCH));
  assign pg = page_r[2:0];

  // Busy length and reason for an accepted command or a pending log
  always_comb begin
    start_kind = KIND_NONE;
    busy_len = '0;
    if (cmd_take && cmd.code == CODE_SAVE_ALL) begin
      start_kind = KIND_SAVE;
      busy_len = CNT_W'(MASS_CYC);
    end else if (cmd_take && cmd.code == CODE_LOAD_ALL) begin
      start_kind = KIND_LOAD;
      busy_len = CNT_W'(LOAD_ALL_CYC);
    end else if (cmd_take && cmd.code == CODE_LOG_CLEAR) begin
      start_kind = KIND_LCLR;
      busy_len = CNT_W'(LOG_CLEAR_CYC);
    end else if (cmd_take && cmd.code == CODE_LOG_STORE) begin
      start_kind = KIND_LSTO;
      busy_len = CNT_W'(LOG_STORE_CYC);
    end else if (cmd_take && cmd.code == CODE_LOG_LOAD) begin
      start_kind = KIND_LLOAD;
      busy_len = CNT_W'(LOG_LOAD_CYC);
    end else if (wr_take && cmd.code == CODE_VCFG) begin
      start_kind = KIND_VCFG;
      busy_len = CNT_W'(CYC_VCFG);
    end else if (state_r == PCBM_IDLE && log_pend_r && !cmd.valid) begin
      start_kind = KIND_LAUTO;
      busy_len = CNT_W'(LOG_AUTO_CYC);
    end
  end

  // Busy state machine: counts down and releases on its own
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= PCBM_IDLE;
      busy_cnt_r <= '0;
      busy_kind_r <= KIND_NONE;
    end else begin
      case (state_r)
        PCBM_IDLE: begin
          if (start_kind != KIND_NONE) begin
            state_r <= PCBM_BUSY;
            busy_cnt_r <= busy_len - CNT_W'(1);
            busy_kind_r <= start_kind;
          end
        end
        PCBM_BUSY: begin
          if (busy_cnt_r == '0) begin
            state_r <= PCBM_IDLE;
            busy_kind_r <= KIND_NONE;
          end else begin
            busy_cnt_r <= busy_cnt_r - CNT_W'(1);
          end
        end
        default: state_r <= PCBM_IDLE;
      endcase
    end
  end
  assign busy_r = (state_r == PCBM_BUSY);

  // One-time internal fault log: pended until idle, enabled by fault_log_en
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      log_pend_r <= 1'b0;
      log_done_r <= 1'b0;
    end else if (start_kind == KIND_LAUTO) begin
      log_pend_r <= 1'b0;
      log_done_r <= 1'b1;
    end else if ((fault_event || (|ton_flt_r)) && fault_log_en && !log_done_r) begin
      log_pend_r <= 1'b1;
    end
  end

  // Sticky busy status bit; set wins over clear-faults
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_seen_r <= 1'b0;
    end else if (busy_r) begin
      busy_seen_r <= 1'b1;
    end else if (clr_fire) begin
      busy_seen_r <= 1'b0;
    end
  end

  // Delayed clear-faults: commands keep flowing while it counts
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      clr_pend_r <= 1'b0;
      clr_cnt_r <= '0;
      clr_page_r <= '0;
    end else if (wr_take && cmd.code == CODE_CLEAR && page_ok) begin
      clr_pend_r <= 1'b1;
      clr_cnt_r <= CNT_W'(CLEAR_CYC) - CNT_W'(1);
      clr_page_r <= pg;
    end else if (clr_pend_r) begin
      if (clr_cnt_r == '0) begin
        clr_pend_r <= 1'b0;
      end else begin
        clr_cnt_r <= clr_cnt_r - CNT_W'(1);
      end
    end
  end
  assign clr_fire = clr_pend_r && (clr_cnt_r == '0);

  // Unpaged registers; full lock leaves only the lock level writable
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      page_r <= RST_PAGE;
      wlock_r <= RST_WLOCK;
      vin_on_r <= RST_VIN_ON;
      vin_off_r <= RST_VIN_OFF;
      ot_lvl_r <= RST_OT_LVL;
    end else if (wr_take) begin
      if (cmd.code == CODE_WLOCK) begin
        wlock_r <= cmd.data[7:0];
      end else if (!wlock_r[WL_ALL_BIT]) begin
        case (cmd.code)
          CODE_PAGE: page_r <= cmd.data[7:0];
          CODE_VIN_ON: vin_on_r <= cmd.data;
          CODE_VIN_OFF: vin_off_r <= cmd.data;
          CODE_OT_LVL: ot_lvl_r <= cmd.data;
          default: ;
        endcase
      end
    end
  end

  // Paged registers: only the selected channel is written
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NCH; i++) begin
        oper_r[i] <= RST_OPER;
        on_off_r[i] <= RST_ON_OFF;
        setpt_r[i] <= RST_SETPT;
        ceil_r[i] <= RST_CEIL;
        mhi_r[i] <= RST_MHI;
        mlo_r[i] <= RST_MLO;
        ov_lvl_r[i] <= RST_OV_LVL;
        ov_act_r[i] <= RST_OV_ACT;
        ovw_lvl_r[i] <= RST_OVW_LVL;
        uvw_lvl_r[i] <= RST_UVW_LVL;
        uv_lvl_r[i] <= RST_UV_LVL;
        uv_act_r[i] <= RST_UV_ACT;
      end
    end else if (wr_take && page_ok && !wlock_r[WL_ALL_BIT]) begin
      case (cmd.code)
        CODE_OPERATING_MODE_CTRL: oper_r[pg] <= cmd.data[7:0];
        CODE_ON_OFF: on_off_r[pg] <= cmd.data[7:0];
        CODE_SETPT: setpt_r[pg] <= cmd.data;
        CODE_CEIL: ceil_r[pg] <= cmd.data;
        CODE_MHI: mhi_r[pg] <= cmd.data;
        CODE_MLO: mlo_r[pg] <= cmd.data;
        CODE_OV_LVL: ov_lvl_r[pg] <= cmd.data;
        CODE_OV_ACT: ov_act_r[pg] <= cmd.data[7:0];
        CODE_OVW_LVL: ovw_lvl_r[pg] <= cmd.data;
        CODE_UVW_LVL: uvw_lvl_r[pg] <= cmd.data;
        CODE_UV_LVL: uv_lvl_r[pg] <= cmd.data;
        CODE_UV_ACT: uv_act_r[pg] <= cmd.data[7:0];
        default: ;
      endcase
    end
  end

  // Output targets: margin choice, then ceiling clamp
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      vout_target_r <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        logic [15:0] want;
        want = setpt_r[i];
        if (oper_r[i][OP_MHI_BIT]) begin
          want = mhi_r[i];
        end else if (oper_r[i][OP_MLO_BIT]) begin
          want = mlo_r[i];
        end
        vout_target_r[i] <= (want > ceil_r[i]) ? ceil_r[i] : want;
      end
    end
  end

  // Input supervisor with turn-on and turn-off hysteresis
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      input_ok_r <= 1'b0;
    end else if (input_sense_pin < vin_off_r) begin
      input_ok_r <= 1'b0;
    end else if (input_sense_pin > vin_on_r) begin
      input_ok_r <= 1'b1;
    end
  end

  // Enables drop in the same cycle the input falls below turn-off
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      en_r <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        en_r[i] <= oper_r[i][OP_ON_BIT] && !ton_flt_r[i] && !ov_flt_r[i]
                   && input_ok_r && !(input_sense_pin < vin_off_r);
      end
    end
  end
  assign output_enable_pin = en_r & {NCH{~(input_sense_pin < vin_off_r)}};

  // Turn-on timer and sticky faults per channel; set wins over clear
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ton_flt_r <= '0;
      ov_flt_r <= '0;
      for (int i = 0; i < NCH; i++) begin
        ton_cnt_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (!en_r[i] || vout_sense[i] >= uv_lvl_r[i]) begin
          ton_cnt_r[i] <= '0;
        end else if (ton_cnt_r[i] != CNT_W'(TON_MAX_CYC)) begin
          ton_cnt_r[i] <= ton_cnt_r[i] + CNT_W'(1);
        end
        if (en_r[i] && ton_cnt_r[i] == CNT_W'(TON_MAX_CYC)) begin
          ton_flt_r[i] <= 1'b1;
        end else if (clr_fire && clr_page_r == 3'(i)) begin
          ton_flt_r[i] <= 1'b0;
        end
        if (en_r[i] && vout_sense[i] > ov_lvl_r[i]) begin
          ov_flt_r[i] <= 1'b1;
        end else if (clr_fire && clr_page_r == 3'(i)) begin
          ov_flt_r[i] <= 1'b0;
        end
      end
    end
  end
  assign turn_on_timeout_fault = ton_flt_r;

  // Alert follows real faults only, never the busy condition
  assign any_fault = |(ton_flt_r | ov_flt_r);
  assign alert_out_n = ~any_fault;

  // Read data mux for the selected page
  always_comb begin
    rd_nxt = '0;
    case (cmd.code)
      CODE_PAGE: rd_nxt = {8'h00, page_r};
      CODE_WLOCK: rd_nxt = {8'h00, wlock_r};
      CODE_CAPAB: rd_nxt = {8'h00, VAL_CAPAB};
      CODE_VFMT: rd_nxt = {8'h00, VAL_VFMT};
      CODE_VIN_ON: rd_nxt = vin_on_r;
      CODE_VIN_OFF: rd_nxt = vin_off_r;
      CODE_OT_LVL: rd_nxt = ot_lvl_r;
      default: begin
        if (page_ok) begin
          case (cmd.code)
            CODE_OPERATING_MODE_CTRL: rd_nxt = {8'h00, oper_r[pg]};
            CODE_ON_OFF: rd_nxt = {8'h00, on_off_r[pg]};
            CODE_SETPT: rd_nxt = setpt_r[pg];
            CODE_CEIL: rd_nxt = ceil_r[pg];
            CODE_MHI: rd_nxt = mhi_r[pg];
            CODE_MLO: rd_nxt = mlo_r[pg];
            CODE_OV_LVL: rd_nxt = ov_lvl_r[pg];
            CODE_OV_ACT: rd_nxt = {8'h00, ov_act_r[pg]};
            CODE_OVW_LVL: rd_nxt = ovw_lvl_r[pg];
            CODE_UVW_LVL: rd_nxt = uvw_lvl_r[pg];
            CODE_UV_LVL: rd_nxt = uv_lvl_r[pg];
            CODE_UV_ACT: rd_nxt = {8'h00, uv_act_r[pg]};
            CODE_STAT_BYTE: begin
              rd_nxt[SW_BUSY_BIT] = busy_seen_r;
            end
            CODE_STAT_WORD: begin
              rd_nxt[SW_BUSY_BIT] = busy_seen_r;
              rd_nxt[SW_VOUT_BIT] = ov_flt_r[pg] | ton_flt_r[pg];
            end
            CODE_STAT_VOUT: begin
              rd_nxt[SV_OV_BIT] = ov_flt_r[pg];
              rd_nxt[SV_UV_BIT] = ton_flt_r[pg];
              rd_nxt[SV_TON_BIT] = ton_flt_r[pg];
            end
            default: rd_nxt = '0;
          endcase
        end
      end
    endcase
  end

  // Read answer registered one cycle after an accepted read
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_r <= '0;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= cmd_take && !cmd.write;
      if (cmd_take && !cmd.write) begin
        rd_data_r <= rd_nxt;
      end
    end
  end
endmodule : pcbm_core

// *** pkg/pcbm_pkg.sv ***
package pcbm_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int NCH = 8;
  // Command codes
  localparam logic [7:0] CODE_PAGE = 8'h00;
  localparam logic [7:0] CODE_OPERATING_MODE_CTRL = 8'h01;
  localparam logic [7:0] CODE_ON_OFF = 8'h02;
  localparam logic [7:0] CODE_CLEAR = 8'h03;
  localparam logic [7:0] CODE_WLOCK = 8'h10;
  localparam logic [7:0] CODE_SAVE_ALL = 8'h15;
  localparam logic [7:0] CODE_LOAD_ALL = 8'h16;
  localparam logic [7:0] CODE_CAPAB = 8'h19;
  localparam logic [7:0] CODE_VFMT = 8'h20;
  localparam logic [7:0] CODE_SETPT = 8'h21;
  localparam logic [7:0] CODE_CEIL = 8'h24;
  localparam logic [7:0] CODE_MHI = 8'h25;
  localparam logic [7:0] CODE_MLO = 8'h26;
  localparam logic [7:0] CODE_VIN_ON = 8'h35;
  localparam logic [7:0] CODE_VIN_OFF = 8'h36;
  localparam logic [7:0] CODE_OV_LVL = 8'h40;
  localparam logic [7:0] CODE_OV_ACT = 8'h41;
  localparam logic [7:0] CODE_OVW_LVL = 8'h42;
  localparam logic [7:0] CODE_UVW_LVL = 8'h43;
  localparam logic [7:0] CODE_UV_LVL = 8'h44;
  localparam logic [7:0] CODE_UV_ACT = 8'h45;
  localparam logic [7:0] CODE_OT_LVL = 8'h4f;
  localparam logic [7:0] CODE_STAT_BYTE = 8'h78;
  localparam logic [7:0] CODE_STAT_WORD = 8'h79;
  localparam logic [7:0] CODE_STAT_VOUT = 8'h7a;
  localparam logic [7:0] CODE_LOG_CLEAR = 8'hd0;
  localparam logic [7:0] CODE_LOG_STORE = 8'hd1;
  localparam logic [7:0] CODE_LOG_LOAD = 8'hd2;
  localparam logic [7:0] CODE_VCFG = 8'hd3;
  // Reset values and fixed read values
  localparam logic [7:0] RST_PAGE = 8'h00;
  localparam logic [7:0] RST_OPER = 8'h00;
  localparam logic [7:0] RST_ON_OFF = 8'h12;
  localparam logic [7:0] RST_WLOCK = 8'h00;
  localparam logic [7:0] VAL_CAPAB = 8'he0;
  localparam logic [7:0] VAL_VFMT = 8'h13;
  localparam logic [15:0] RST_SETPT = 16'h2000;
  localparam logic [15:0] RST_CEIL = 16'h8000;
  localparam logic [15:0] RST_MHI = 16'h219a;
  localparam logic [15:0] RST_MLO = 16'h1e66;
  localparam logic [15:0] RST_VIN_ON = 16'hd280;
  localparam logic [15:0] RST_VIN_OFF = 16'hd240;
  localparam logic [15:0] RST_OV_LVL = 16'h2333;
  localparam logic [7:0] RST_OV_ACT = 8'h80;
  localparam logic [15:0] RST_OVW_LVL = 16'h2266;
  localparam logic [15:0] RST_UVW_LVL = 16'h1d9a;
  localparam logic [15:0] RST_UV_LVL = 16'h1ccd;
  localparam logic [7:0] RST_UV_ACT = 8'h7f;
  localparam logic [15:0] RST_OT_LVL = 16'heaa8;
  // Field positions
  localparam int OP_ON_BIT = 7;
  localparam int OP_MHI_BIT = 5;
  localparam int OP_MLO_BIT = 4;
  localparam int WL_ALL_BIT = 7;
  localparam int SW_BUSY_BIT = 7;
  localparam int SW_VOUT_BIT = 15;
  localparam int SV_OV_BIT = 7;
  localparam int SV_UV_BIT = 4;
  localparam int SV_TON_BIT = 2;
  // Timing in printed units and derived cycle counts
  localparam int T_MASS_MS = 100;
  localparam int T_LOAD_ALL_MS = 30;
  localparam int T_LOG_CLEAR_MS = 175;
  localparam int T_LOG_STORE_MS = 20;
  localparam int T_LOG_AUTO_MS = 10;
  localparam int T_LOG_LOAD_MS = 2;
  localparam int T_VCFG_US = 50;
  localparam int T_CLEAR_US = 500;
  localparam int T_TON_MAX_MS = 15;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int CYC_VCFG = T_VCFG_US * CYC_PER_US;
  localparam int CNT_W = 24;
  // Busy reasons
  localparam logic [2:0] KIND_NONE = 3'h0;
  localparam logic [2:0] KIND_SAVE = 3'h1;
  localparam logic [2:0] KIND_LOAD = 3'h2;
  localparam logic [2:0] KIND_LCLR = 3'h3;
  localparam logic [2:0] KIND_LSTO = 3'h4;
  localparam logic [2:0] KIND_LAUTO = 3'h5;
  localparam logic [2:0] KIND_LLOAD = 3'h6;
  localparam logic [2:0] KIND_VCFG = 3'h7;
  typedef enum logic [1:0] {
    PCBM_IDLE = 2'b01,
    PCBM_BUSY = 2'b10
  } pcbm_state_t;
  // One complete command, presented at its stop condition
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] data;
  } pcbm_cmd_t;
endpackage : pcbm_pkg

// *** bench/pcbm_host.sv ***
`timescale 1ns/1ps
// Host model: one command per request
module pcbm_host
  import pcbm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic req,
  input wire pcbm_cmd_t req_cmd,
  output pcbm_cmd_t cmd,
  input wire logic cmd_ack,
  output logic done,
  output logic acked
);
  // Command stands one cycle; released lines show inverted stale bits
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd <= '0;
    end else begin
      cmd <= req ? {1'b1, req_cmd[24:0]} : {1'b0, ~cmd[24:0]};
    end
  end
  // Answer latched at the taking edge
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      done <= 1'b0;
      acked <= 1'b0;
    end else begin
      done <= cmd.valid;
      acked <= cmd_ack;
    end
  end
endmodule : pcbm_host

// *** bench/pcbm_core_assertions.sv ***
`timescale 1ns/1ps
module pcbm_core_assertions
  import pcbm_pkg::*;
#(
  parameter int MASS_CYC = 20,
  parameter int LOAD_ALL_CYC = 30,
  parameter int LOG_CLEAR_CYC = 40,
  parameter int LOG_STORE_CYC = 25,
  parameter int LOG_AUTO_CYC = 15,
  parameter int LOG_LOAD_CYC = 10
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire pcbm_cmd_t cmd,
  input wire logic cmd_ack,
  input wire logic [15:0] rd_data_r,
  input wire logic rd_valid_r,
  input wire logic [15:0] input_sense_pin,
  input wire logic [NCH-1:0] output_enable_pin,
  input wire logic busy_r,
  input wire logic [2:0] busy_kind_r,
  input wire logic alert_out_n
);
  logic taken;
  logic lock_r;
  logic [15:0] off_lvl_r;
  logic [15:0] busy_len_r;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  assign taken = cmd.valid && cmd_ack;
  // Busy length owed by each reason
  function automatic int len_of(input logic [2:0] k);
    case (k)
      KIND_SAVE: return MASS_CYC;
      KIND_LOAD: return LOAD_ALL_CYC;
      KIND_LCLR: return LOG_CLEAR_CYC;
      KIND_LSTO: return LOG_STORE_CYC;
      KIND_LAUTO: return LOG_AUTO_CYC;
      KIND_LLOAD: return LOG_LOAD_CYC;
      KIND_VCFG: return CYC_VCFG;
      default: return 0;
    endcase
  endfunction : len_of
  // Length of the running busy interval
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_len_r <= 16'h0000;
    end else begin
      busy_len_r <= busy_r ? busy_len_r + 16'h0001 : 16'h0000;
    end
  end
  // Shadow of the turn-off level under the write lock
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_r <= 1'b0;
      off_lvl_r <= 16'hd240;
    end else if (taken && cmd.write) begin
      if (cmd.code == CODE_WLOCK) lock_r <= cmd.data[WL_ALL_BIT];
      if (cmd.code == CODE_VIN_OFF && !lock_r) off_lvl_r <= cmd.data;
    end
  end
  sequence busy_cmd_s;
    taken && cmd.write && cmd.code inside {8'h15, 8'h16, 8'hd0, 8'hd1, 8'hd2, 8'hd3};
  endsequence
  sequence rd_cmd_s;
    taken && !cmd.write;
  endsequence
  busy_start_a: assert property (busy_cmd_s |=> busy_r)
    else $error("busy not entered");
  busy_len_a: assert property ($fell(busy_r) |-> int'(busy_len_r) == len_of($past(busy_kind_r)))
    else $error("busy length wrong");
  busy_nack_a: assert property (busy_r && cmd.valid |-> !cmd_ack)
    else $error("command taken while busy");
  busy_alert_a: assert property ($rose(busy_r) |-> $stable(alert_out_n))
    else $error("alert moved with busy");
  clear_accept_a: assert property (taken && cmd.write && cmd.code == CODE_CLEAR |=>
    !busy_r || busy_kind_r == KIND_LAUTO)
    else $error("clear made the port busy");
  read_pulse_a: assert property (rd_cmd_s |=> rd_valid_r)
    else $error("read answer missing");
  read_cause_a: assert property (rd_valid_r |-> $past(taken) && !$past(cmd.write))
    else $error("read answer without read");
  capab_value_a: assert property (rd_cmd_s ##0 cmd.code == CODE_CAPAB |=> rd_data_r == 16'h00e0)
    else $error("protocol_feature_summary value wrong");
  format_value_a: assert property (rd_cmd_s ##0 cmd.code == CODE_VFMT |=> rd_data_r == 16'h0013)
    else $error("format value wrong");
  input_kill_a: assert property (input_sense_pin < off_lvl_r |-> output_enable_pin == '0)
    else $error("enable on below turn-off");
endmodule : pcbm_core_assertions
bind pcbm_core pcbm_core_assertions #(.MASS_CYC(MASS_CYC), .LOAD_ALL_CYC(LOAD_ALL_CYC),
  .LOG_CLEAR_CYC(LOG_CLEAR_CYC), .LOG_STORE_CYC(LOG_STORE_CYC), .LOG_AUTO_CYC(LOG_AUTO_CYC),
  .LOG_LOAD_CYC(LOG_LOAD_CYC)) u_pcbm_core_assertions (.*);

// *** bench/test_pcbm_command_busy_and_map.sv ***
`timescale 1ns/1ps
module test_pcbm_command_busy_and_map
  import pcbm_pkg::*;
;
  logic sys_clk, arst_n, req, cmd_ack, rd_valid_r, fault_event, fault_log_en;
  logic busy_r, alert_out_n, done, acked;
  pcbm_cmd_t req_cmd, cmd;
  logic [15:0] rd_data_r, input_sense_pin;
  logic [NCH-1:0][15:0] vout_sense, vout_target_r;
  logic [NCH-1:0] output_enable_pin, turn_on_timeout_fault;
  logic [2:0] busy_kind_r;
  logic ack_q[$];
  logic [15:0] rd_q[$];
  int err_count, samples_checked, cyc;
  logic [31:0] seed;
  localparam int MASS_CYC = 20, LOAD_ALL_CYC = 30, LOG_CLEAR_CYC = 40, LOG_STORE_CYC = 25;
  localparam int LOG_AUTO_CYC = 15, LOG_LOAD_CYC = 10, CLEAR_CYC = 12, TON_MAX_CYC = 50;
  logic [23:0] map [19] = '{24'h00_0000, 24'h01_0000, 24'h02_0012, 24'h10_0000, 24'h19_00e0,
    24'h20_0013, 24'h21_2000, 24'h24_8000, 24'h25_219a, 24'h26_1e66, 24'h35_d280, 24'h36_d240,
    24'h40_2333, 24'h41_0080, 24'h42_2266, 24'h43_1d9a, 24'h44_1ccd, 24'h45_007f, 24'h4f_eaa8};
  logic [7:0] bz_code [6] = '{8'h15, 8'h16, 8'hd0, 8'hd1, 8'hd2, 8'hd3};
  logic [2:0] bz_kind [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
  // 25 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  pcbm_core #(.MASS_CYC(MASS_CYC), .LOAD_ALL_CYC(LOAD_ALL_CYC), .LOG_CLEAR_CYC(LOG_CLEAR_CYC),
    .LOG_STORE_CYC(LOG_STORE_CYC), .LOG_AUTO_CYC(LOG_AUTO_CYC), .LOG_LOAD_CYC(LOG_LOAD_CYC),
    .CLEAR_CYC(CLEAR_CYC), .TON_MAX_CYC(TON_MAX_CYC)) u_pcbm_core (.*);
  pcbm_host u_pcbm_host (.*);
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic tally_and_finish;
    $display("checked=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk16(input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk16
  task automatic chk_ack(input logic e, input logic g);
    chk16({15'h0000, e}, {15'h0000, g});
  endtask : chk_ack
  // One command; expected answers noted first
  task automatic send(input logic wr, input logic [7:0] code, input logic [15:0] data,
    input logic ack, input logic [15:0] rd);
    @(posedge sys_clk);
    ack_q.push_back(ack);
    if (!wr && ack) rd_q.push_back(rd);
    req <= 1'b1;
    req_cmd <= {1'b0, wr, code, data};
    @(posedge sys_clk);
    req <= 1'b0;
    @(posedge sys_clk);
  endtask : send
  task automatic put(input logic [7:0] code, input logic [15:0] data);
    send(1'b1, code, data, 1'b1, 16'h0000);
  endtask : put
  task automatic get(input logic [7:0] code, input logic [15:0] rd);
    send(1'b0, code, 16'h0000, 1'b1, rd);
  endtask : get
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic wait_idle;
    repeat (1500) if (busy_r === 1'b1) @(posedge sys_clk);
    chk_ack(1'b0, busy_r);
  endtask : wait_idle
  // Oldest note taken whenever an answer appears
  always @(posedge sys_clk) begin
    if (done === 1'b1) chk_ack(ack_q.pop_front(), acked);
    if (rd_valid_r === 1'b1) chk16(rd_q.pop_front(), rd_data_r);
  end
  // Hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      err_count++;
      tally_and_finish();
    end
  end
  initial begin
    arst_n = 1'b0;
    req = 1'b0;
    req_cmd = '0;
    fault_event = 1'b0;
    fault_log_en = 1'b0;
    input_sense_pin = 16'h0000;
    vout_sense = {NCH{16'h2000}};
    err_count = 0;
    samples_checked = 0;
    cyc = 0;
    seed = 32'h0001_442a;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    foreach (map[i]) get(map[i][23:16], map[i][15:0]);
    put(CODE_PAGE, 16'h0003);
    put(CODE_CEIL, 16'h0800);
    put(CODE_OPERATING_MODE_CTRL, 16'h00a0);
    tick(3);
    chk16(16'h0800, vout_target_r[3]);
    chk16(16'h2000, vout_target_r[0]);
    put(CODE_CEIL, 16'hffff);
    tick(3);
    chk16(16'h219a, vout_target_r[3]);
    put(CODE_OPERATING_MODE_CTRL, 16'h0090);
    tick(3);
    chk16(16'h1e66, vout_target_r[3]);
    put(CODE_PAGE, 16'h0000);
    get(CODE_CEIL, 16'h8000);
    put(CODE_PAGE, 16'h0003);
    chk16(16'h0000, 16'(output_enable_pin));
    @(posedge sys_clk);
    input_sense_pin <= 16'hd290;
    // Random levels inside the good band
    repeat (60) begin
      @(posedge sys_clk);
      vout_sense[3] <= 16'h1cce + 16'(seed % 32'h0000_0665);
      seed = xs(seed);
    end
    tick(1);
    chk16(16'h0008, 16'(output_enable_pin));
    chk16(16'h0000, 16'(turn_on_timeout_fault));
    @(posedge sys_clk);
    input_sense_pin <= 16'hd250;
    tick(3);
    chk16(16'h0008, 16'(output_enable_pin));
    @(posedge sys_clk);
    input_sense_pin <= 16'hd200;
    #1 chk16(16'h0000, 16'(output_enable_pin));
    @(posedge sys_clk);
    input_sense_pin <= 16'hd290;
    vout_sense[3] <= 16'h1ccc;
    tick(40);
    chk16(16'h0000, 16'(turn_on_timeout_fault));
    tick(20);
    chk16(16'h0008, 16'(turn_on_timeout_fault));
    chk_ack(1'b0, busy_r);
    chk_ack(1'b0, alert_out_n);
    @(posedge sys_clk);
    vout_sense[3] <= 16'h2000;
    put(CODE_CLEAR, 16'h0000);
    get(CODE_CAPAB, 16'h00e0);
    #1 chk16(16'h0008, 16'(turn_on_timeout_fault));
    tick(16);
    chk16(16'h0000, 16'(turn_on_timeout_fault));
    // Internal log write, then a second fault that must not log again
    for (int k = 1; k >= 0; k--) begin
      @(posedge sys_clk);
      fault_log_en <= 1'b1;
      fault_event <= 1'b1;
      @(posedge sys_clk);
      fault_event <= 1'b0;
      tick(2);
      chk16(k ? 16'(KIND_LAUTO) : 16'h0000, 16'(busy_kind_r));
      chk_ack(1'b1, alert_out_n);
      wait_idle();
    end
    foreach (bz_code[i]) begin
      put(bz_code[i], 16'h0000);
      #1 chk16(16'(bz_kind[i]), 16'(busy_kind_r));
      chk_ack(1'b1, alert_out_n);
      send(1'b0, CODE_CAPAB, 16'h0000, 1'b0, 16'h0000);
      wait_idle();
      get(CODE_CAPAB, 16'h00e0);
    end
    @(posedge sys_clk);
    arst_n <= 1'b0;
    @(posedge sys_clk);
    arst_n <= 1'b1;
    get(CODE_PAGE, 16'h0000);
    tick(3);
    tally_and_finish();
  end
endmodule : test_pcbm_command_busy_and_map
